/* src/boundary_scan_data_regs.sv */
/*
  Boundary chain, run-test control register, bypass stage and instruction
  register with opcode decode. Scan logic runs on tck; core-side view of
  modes and cell data is carried to sys_clk by a req/ack handshake.
  Assumes an external TAP state machine on tck gives one-hot state strobes
  and that pin and core signals are asynchronous to tck.
*/
`timescale 1ns/1ps
`include "scan_regs_defs.svh"

// What this block does
// RULE1: Boundary chain is forty cells long
// RULE2: Instruction picks capture source; run-test changes cells
// RULE3: All boundary cells reset to zero
// RULE4: Drive-enable cells capture ORed inverted enables
// RULE5: Drive-enable cells gate port output drive
// RULE6: Chain shifts tdi through 39 to 0
// RULE7: Fixed cell assignment for enables, controls, ports
// RULE8: Eleven-bit run-test control register selects operations
// RULE9: Control register holds value during capture
// RULE10: Control register resets to unmasked signature code
// RULE11: Control register shifts tdi through 10 to 0
// RULE12: Bits 10-3 masks, bits 2-0 op
// RULE13: Bypass is one stage capturing zero
// RULE14: Bit seven gives even parity to opcodes
// RULE15: Opcodes 00,03 scan boundary in test mode
// RULE16: Listed and undefined opcodes run bypass normally
// RULE17: Opcode 82 samples boundary in normal mode
// RULE18: Unimplemented family instructions fall back to bypass
// RULE19: Highz modified test, clamp test, both bypass
// RULE20: Opcode 09 runs control-register operation via bypass
// RULE21: Read and self-check opcodes select boundary chain
// RULE22: Toggle uses bypass; 8e/0f select control register
// RULE23: Instruction capture loads 10000001
// RULE24: Instruction register resets to all ones
// RULE25: Op code decode of run-test operations
// RULE26: Masked inputs excluded from signature
// RULE27: Controller loads control register before run-test
module boundary_scan_data_regs
  import scan_regs_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       sys_ce,
  input  wire logic       tck,
  input  wire logic       tdi,
  input  wire logic       tap_reset_state,
  input  wire logic       tap_run_idle,
  input  wire logic       tap_capture_dr,
  input  wire logic       tap_shift_dr,
  input  wire logic       tap_update_dr,
  input  wire logic       tap_capture_ir,
  input  wire logic       tap_shift_ir,
  input  wire logic       tap_update_ir,
  output logic            tdo,
  output logic            tdo_oe,
  input  wire logic [7:0] a_pin_in,
  input  wire logic [7:0] b_pin_in,
  input  wire logic [5:0] ctrl_pin_in,
  input  wire logic [7:0] core_a_out,
  input  wire logic [7:0] core_b_out,
  output logic            test_mode,
  output logic            highz_mode,
  output logic            a_side_drive_enable,
  output logic            b_side_drive_enable,
  output logic [7:0]      a_test_out,
  output logic [7:0]      b_test_out,
  output logic [7:0]      core_a_in_test,
  output logic [7:0]      core_b_in_test,
  output logic [5:0]      ctrl_test
);
  import scan_regs_pkg::*;

  localparam int ALL_W = 38;
  localparam int PUB_W = `CHAIN_LEN + 2;

  // Pin and core samples on tck, two flops before use
  logic [ALL_W-1:0]      pins_s1_reg;
  logic [ALL_W-1:0]      pins_s2_reg;
  logic [7:0]            a_in_s;
  logic [7:0]            b_in_s;
  logic [5:0]            ctrl_s;
  logic [7:0]            a_core_s;
  logic [7:0]            b_core_s;

  logic [`IR_LEN-1:0]    ir_shift_reg;
  logic [`IR_LEN-1:0]    ir_reg;
  logic [`CHAIN_LEN-1:0] chain_reg;
  logic [`CHAIN_LEN-1:0] chain_next;
  logic [`CHAIN_LEN-1:0] shadow_reg;
  logic [`CTRL_LEN-1:0]  ctrl_shift_reg;
  logic [`CTRL_LEN-1:0]  run_control_reg;
  logic                  bypass_reg;
  logic                  tdo_next;

  dr_sel_e               dr_sel;
  cap_src_e              cap_src;
  logic                  dec_test;
  logic                  dec_highz;
  logic                  dec_run_test;
  logic                  dec_toggle;

  // Instruction decode; odd-parity codes miss every entry   [RULE14]
  always_comb begin
    dr_sel       = SEL_BYPASS;
    cap_src      = CAP_NONE;
    dec_test     = 1'b0;
    dec_highz    = 1'b0;
    dec_run_test = 1'b0;
    dec_toggle   = 1'b0;
    case (ir_reg)
      `OP_EXTEST0, `OP_EXTEST1: begin // [RULE15]
        dr_sel   = SEL_BOUNDARY;
        cap_src  = CAP_PINS;
        dec_test = 1'b1;
      end
      `OP_SAMPLE: begin // [RULE17]
        dr_sel  = SEL_BOUNDARY;
        cap_src = CAP_PINS;
      end
      `OP_HIGHZ: begin // [RULE19]
        dec_test  = 1'b1;
        dec_highz = 1'b1;
      end
      `OP_CLAMP: begin // [RULE19]
        dec_test = 1'b1;
      end
      `OP_RUN_TEST: begin // [RULE20]
        dec_test     = 1'b1;
        dec_run_test = 1'b1;
      end
      `OP_READ_NORMAL: begin // [RULE21]
        dr_sel  = SEL_BOUNDARY;
        cap_src = CAP_HOLD;
      end
      `OP_READ_TEST: begin // [RULE21]
        dr_sel   = SEL_BOUNDARY;
        cap_src  = CAP_HOLD;
        dec_test = 1'b1;
      end
      `OP_SELF_CHECK: begin // [RULE21]
        dr_sel  = SEL_BOUNDARY;
        cap_src = CAP_INV;
      end
      `OP_TOGGLE_OUT: begin // [RULE22]
        dec_test   = 1'b1;
        dec_toggle = 1'b1;
      end
      `OP_CTRL_NORMAL: begin // [RULE22]
        dr_sel = SEL_CONTROL;
      end
      `OP_CTRL_TEST: begin // [RULE22]
        dr_sel   = SEL_CONTROL;
        dec_test = 1'b1;
      end
      default: begin // [RULE16] [RULE18]
        dr_sel = SEL_BYPASS;
      end
    endcase
  end

  // Synchroniser; stage one feeds only stage two
  always_ff @(posedge tck) begin
    pins_s1_reg <= {ctrl_pin_in, a_pin_in, b_pin_in, core_a_out,
                    core_b_out};
    pins_s2_reg <= pins_s1_reg;
  end

  assign ctrl_s   = pins_s2_reg[37:32];
  assign a_in_s   = pins_s2_reg[31:24];
  assign b_in_s   = pins_s2_reg[23:16];
  assign a_core_s = pins_s2_reg[15:8];
  assign b_core_s = pins_s2_reg[7:0];

  // Instruction register
  always_ff @(posedge tck) begin
    if (tap_reset_state) begin
      ir_shift_reg <= `IR_RESET;
      ir_reg       <= `IR_RESET; // [RULE24]
    end else begin
      if (tap_capture_ir) begin
        ir_shift_reg <= `IR_CAPTURE; // [RULE23]
      end else if (tap_shift_ir) begin
        ir_shift_reg <= {tdi, ir_shift_reg[`IR_LEN-1:1]};
      end
      if (tap_update_ir) begin
        ir_reg <= ir_shift_reg;
      end
    end
  end

  // Run-test step, one generate lane per port bit
  logic                  run_valid;
  logic [2:0]            run_op;
  logic [7:0]            run_mask;
  logic [7:0]            a_in_step;
  logic [7:0]            b_in_step;
  logic [7:0]            a_out_step;
  logic [7:0]            b_out_step;
  logic                  run_active;

  assign run_op   = run_control_reg[`CTRL_OP_MSB:0];
  assign run_mask = run_control_reg[`CTRL_LEN-1:`CTRL_MASK_LSB]; // [RULE12]
  // Opcode 09 run operations only act with one data direction selected; toggle acts with either or both
  assign run_valid = chain_reg[`CELL_A_DRIVE_EN] !=
                     chain_reg[`CELL_B_DRIVE_EN];
  assign run_active = tap_run_idle && (dec_toggle ||
                      (dec_run_test && run_valid)); // [RULE2]

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_lane
      localparam int LO = (gi == 0) ? 7 : gi - 1;
      always_comb begin
        a_in_step[gi]  = chain_reg[`CELL_A_IN_LSB + gi];
        b_in_step[gi]  = chain_reg[`CELL_B_IN_LSB + gi];
        a_out_step[gi] = chain_reg[`CELL_A_OUT_LSB + gi];
        b_out_step[gi] = chain_reg[`CELL_B_OUT_LSB + gi];
        if (dec_toggle) begin
          a_out_step[gi] = ~chain_reg[`CELL_A_OUT_LSB + gi];
          b_out_step[gi] = ~chain_reg[`CELL_B_OUT_LSB + gi];
        end else if (run_op[1:0] == `RUN_SAMPLE_TOG) begin // [RULE25]
          a_in_step[gi]  = a_in_s[gi];
          b_in_step[gi]  = b_in_s[gi];
          a_out_step[gi] = ~chain_reg[`CELL_A_OUT_LSB + gi];
          b_out_step[gi] = ~chain_reg[`CELL_B_OUT_LSB + gi];
        end else begin
          // Signature lanes: shift from the lane below; masked inputs add nothing
          if (run_op[1:0] != `RUN_PATTERN) begin
            a_in_step[gi] = chain_reg[`CELL_A_IN_LSB + LO] ^
                            (a_in_s[gi] & ~run_mask[gi]); // [RULE26]
            b_in_step[gi] = chain_reg[`CELL_B_IN_LSB + LO] ^
                            (b_in_s[gi] & ~run_mask[gi]); // [RULE26]
          end
          // Pattern lanes: rotate with feedback from top bit
          if (run_op[1:0] == `RUN_PATTERN ||
              run_op == 3'b011) begin // [RULE25]
            a_out_step[gi] = chain_reg[`CELL_A_OUT_LSB + LO] ^
                             (gi == 0 ? 1'b0 : chain_reg[`CELL_A_OUT_LSB + 7]);
            b_out_step[gi] = chain_reg[`CELL_B_OUT_LSB + LO] ^
                             (gi == 0 ? 1'b0 : chain_reg[`CELL_B_OUT_LSB + 7]);
          end
        end
      end
    end
  endgenerate

  // Count-up variant drives outputs as a binary counter
  logic [7:0] a_count;
  logic [7:0] b_count;
  assign a_count = chain_reg[`CELL_A_OUT_LSB +: 8] + 8'h01;
  assign b_count = chain_reg[`CELL_B_OUT_LSB +: 8] + 8'h01;

  // Boundary chain next value
  always_comb begin
    chain_next = chain_reg;
    if (tap_capture_dr && dr_sel == SEL_BOUNDARY) begin // [RULE2]
      case (cap_src)
        CAP_PINS: begin
          chain_next[`CELL_B_DRIVE_EN] = ~ctrl_s[5] | ~ctrl_s[1]; // [RULE4]
          chain_next[`CELL_A_DRIVE_EN] = ~ctrl_s[4] | ~ctrl_s[0]; // [RULE4]
          chain_next[37:32] = ctrl_s; // [RULE7]
          chain_next[31:24] = a_in_s;
          chain_next[23:16] = a_core_s;
          chain_next[15:8]  = b_in_s;
          chain_next[7:0]   = b_core_s;
        end
        CAP_INV:  chain_next = ~chain_reg;
        CAP_HOLD: chain_next = chain_reg;
        default:  chain_next = chain_reg;
      endcase
    end else if (tap_shift_dr && dr_sel == SEL_BOUNDARY) begin
      chain_next = {tdi, chain_reg[`CHAIN_LEN-1:1]}; // [RULE6]
    end else if (run_active) begin
      chain_next[31:24] = a_in_step;
      chain_next[15:8]  = b_in_step;
      if (!dec_toggle && run_op == `RUN_SIG_COUNT) begin // [RULE25]
        chain_next[23:16] = a_count;
        chain_next[7:0]   = b_count;
      end else begin
        chain_next[23:16] = a_out_step;
        chain_next[7:0]   = b_out_step;
      end
      if (dec_toggle) begin
        chain_next[31:24] = chain_reg[31:24];
        chain_next[15:8]  = chain_reg[15:8];
      end
    end
  end

  always_ff @(posedge tck) begin
    if (tap_reset_state) begin
      chain_reg  <= `CHAIN_RESET; // [RULE3] [RULE1]
      shadow_reg <= `CHAIN_RESET; // [RULE3]
    end else begin
      chain_reg <= chain_next;
      if ((tap_update_dr && dr_sel == SEL_BOUNDARY) || run_active) begin
        shadow_reg <= (run_active) ? chain_next : chain_reg;
      end
    end
  end

  // Run-test control register; capture leaves it alone
  always_ff @(posedge tck) begin
    if (tap_reset_state) begin
      ctrl_shift_reg  <= `CTRL_RESET; // [RULE10]
      run_control_reg <= `CTRL_RESET; // [RULE10] [RULE8]
    end else if (dr_sel == SEL_CONTROL) begin
      if (tap_capture_dr) begin
        ctrl_shift_reg <= run_control_reg; // [RULE9]
      end else if (tap_shift_dr) begin
        ctrl_shift_reg <= {tdi, ctrl_shift_reg[`CTRL_LEN-1:1]}; // [RULE11]
      end
      if (tap_update_dr) begin
        run_control_reg <= ctrl_shift_reg; // [RULE27]
      end
    end
  end

  // Bypass stage
  always_ff @(posedge tck) begin
    if (tap_reset_state) begin
      bypass_reg <= 1'b0;
    end else if (dr_sel == SEL_BYPASS) begin
      if (tap_capture_dr) begin
        bypass_reg <= 1'b0; // [RULE13]
      end else if (tap_shift_dr) begin
        bypass_reg <= tdi; // [RULE13]
      end
    end
  end

  // Test data out changes on the falling edge
  always_comb begin
    tdo_next = bypass_reg;
    if (tap_shift_ir) begin
      tdo_next = ir_shift_reg[0];
    end else begin
      case (dr_sel)
        SEL_BOUNDARY: tdo_next = chain_reg[0]; // [RULE6]
        SEL_CONTROL:  tdo_next = ctrl_shift_reg[0]; // [RULE11]
        SEL_BYPASS:   tdo_next = bypass_reg;
        default:      tdo_next = bypass_reg;
      endcase
    end
  end

  always_ff @(negedge tck) begin
    if (tap_reset_state) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      tdo    <= tdo_next;
      tdo_oe <= tap_shift_ir | tap_shift_dr;
    end
  end

  // Handshake to sys_clk: outside TAP reset, word is frozen while a request is open
  logic [PUB_W-1:0] pub_reg;
  logic             req_reg;
  logic             ack_s1_reg;
  logic             ack_s2_reg;
  logic             ack_reg;
  logic             req_s1_reg;
  logic             req_s2_reg;

  always_ff @(posedge tck) begin
    ack_s1_reg <= ack_reg;
    ack_s2_reg <= ack_s1_reg;
  end

  // In reset the request is held opposite the ack, so it starts out defined;
  // a round open on entry may carry one mixed word, then zeros follow
  always_ff @(posedge tck) begin
    if (tap_reset_state) begin
      pub_reg <= {PUB_W{1'b0}};
      req_reg <= ~ack_s2_reg;
    end else if (req_reg == ack_s2_reg) begin
      pub_reg <= {dec_highz, dec_test, shadow_reg};
      req_reg <= ~req_reg;
    end
  end

  // Sys side; sys_ce freezes this domain only
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
    end else if (sys_ce) begin
      req_s1_reg <= req_reg;
      req_s2_reg <= req_s1_reg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ack_reg             <= 1'b0;
      test_mode           <= 1'b0;
      highz_mode          <= 1'b0;
      a_side_drive_enable <= 1'b0;
      b_side_drive_enable <= 1'b0;
      a_test_out          <= 8'h00;
      b_test_out          <= 8'h00;
      core_a_in_test      <= 8'h00;
      core_b_in_test      <= 8'h00;
      ctrl_test           <= 6'h00;
    end else if (sys_ce && req_s2_reg != ack_reg) begin
      ack_reg        <= req_s2_reg;
      highz_mode     <= pub_reg[PUB_W-1];
      test_mode      <= pub_reg[PUB_W-2];
      // Highz overrides the enable cells
      a_side_drive_enable <= pub_reg[`CELL_A_DRIVE_EN] &
                             ~pub_reg[PUB_W-1]; // [RULE5]
      b_side_drive_enable <= pub_reg[`CELL_B_DRIVE_EN] &
                             ~pub_reg[PUB_W-1]; // [RULE5]
      ctrl_test      <= pub_reg[37:32];
      core_a_in_test <= pub_reg[31:24];
      a_test_out     <= pub_reg[23:16];
      core_b_in_test <= pub_reg[15:8];
      b_test_out     <= pub_reg[7:0];
    end
  end

endmodule : boundary_scan_data_regs

/* src/scan_regs_defs.svh */
/*
  Constants for the boundary-scan data registers and instruction decode:
  widths, reset values, field positions and opcodes.
  Assumes inclusion by bare name from the package and design files.
*/
`ifndef SCAN_REGS_DEFS_SVH
`define SCAN_REGS_DEFS_SVH

`define CHAIN_LEN        40
`define CTRL_LEN         11
`define IR_LEN           8
`define CHAIN_RESET      40'h00_0000_0000
`define CTRL_RESET       11'h002
`define IR_RESET         8'hff
`define IR_CAPTURE       8'h81
`define CELL_B_DRIVE_EN  39
`define CELL_A_DRIVE_EN  38
`define CELL_CTRL_LSB    32
`define CELL_A_IN_LSB    24
`define CELL_A_OUT_LSB   16
`define CELL_B_IN_LSB    8
`define CELL_B_OUT_LSB   0
`define CTRL_MASK_LSB    3
`define CTRL_OP_MSB      2
`define OP_EXTEST0       8'h00
`define OP_SAMPLE        8'h82
`define OP_EXTEST1       8'h03
`define OP_HIGHZ         8'h06
`define OP_CLAMP         8'h87
`define OP_RUN_TEST      8'h09
`define OP_READ_NORMAL   8'h0a
`define OP_READ_TEST     8'h8b
`define OP_SELF_CHECK    8'h0c
`define OP_TOGGLE_OUT    8'h8d
`define OP_CTRL_NORMAL   8'h8e
`define OP_CTRL_TEST     8'h0f
`define RUN_SAMPLE_TOG   2'b00
`define RUN_PATTERN      2'b01
`define RUN_SIGNATURE    2'b10
`define RUN_SIG_COUNT    3'b111

`endif

/* src/scan_regs_pkg.sv */
/*
  Types for the boundary-scan data registers: data-register select and
  capture source.
  Assumes scan_regs_defs.svh is on the include path.
*/
package scan_regs_pkg;
  `include "scan_regs_defs.svh"

  typedef enum logic [2:0] {
    SEL_BYPASS   = 3'b001,
    SEL_BOUNDARY = 3'b010,
    SEL_CONTROL  = 3'b100
  } dr_sel_e;

  typedef enum logic [3:0] {
    CAP_PINS = 4'b0001,
    CAP_HOLD = 4'b0010,
    CAP_INV  = 4'b0100,
    CAP_NONE = 4'b1000
  } cap_src_e;
endpackage : scan_regs_pkg

/* sim/tap_host.sv */
/*
  Host side of the scan port: drives one-hot state strobes and tdi,
  reads tdo. Assumes a free-running tck made by the bench.
*/
`timescale 1ns/1ps
module tap_host (
  input  wire logic       tck,
  input  wire logic       tdo,
  output logic            tdi,
  output logic [7:0]      st
);
  // st: reset, idle, cap_dr, sh_dr, upd_dr, cap_ir, sh_ir, upd_ir
  initial begin
    st = 8'h80;
    tdi = 1'b0;
  end

  // Outside shift tdi flips, so a stale bit never passes for data
  task automatic step(input logic [7:0] s, input logic d,
                      output logic q);
    @(posedge tck);
    q = tdo;
    st <= s;
    tdi <= (s[4] || s[1]) ? d : ~tdi;
  endtask : step

  task automatic hold(input logic [7:0] s, input int n);
    logic q;
    repeat (n) step(s, 1'b0, q);
  endtask : hold

  // Bit 0 leaves first; tdi enters at the top of the register
  task automatic scan(input logic ir, input int n,
                      input logic [63:0] din, output logic [63:0] dout);
    logic q;
    dout = '0;
    step(ir ? 8'h04 : 8'h20, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      step(ir ? 8'h02 : 8'h10, din[i], q);
      if (i > 0)
        dout[i-1] = q;
    end
    step(ir ? 8'h01 : 8'h08, 1'b0, q);
    dout[n-1] = q;
    step(8'h40, 1'b0, q);
  endtask : scan
endmodule : tap_host

/* sim/scan_port_chk.sv */
/*
  Assertions on the ports of the scan data register block.
  Assumes one-hot TAP strobes and tdo moving on the tck fall.
*/
`timescale 1ns/1ps
module scan_port_chk (
  input wire logic       sys_clk,
  input wire logic       reset,
  input wire logic       sys_ce,
  input wire logic       tck,
  input wire logic       tap_reset_state,
  input wire logic       tap_run_idle,
  input wire logic       tap_capture_dr,
  input wire logic       tap_shift_dr,
  input wire logic       tap_capture_ir,
  input wire logic       tap_shift_ir,
  input wire logic       tap_update_ir,
  input wire logic       tdo,
  input wire logic       tdo_oe,
  input wire logic       test_mode,
  input wire logic       highz_mode,
  input wire logic       a_side_drive_enable,
  input wire logic       b_side_drive_enable,
  input wire logic [7:0] a_test_out,
  input wire logic [7:0] b_test_out
);
  logic ir_fresh_reg;

  // Reset opcode holds until the first instruction update
  always_ff @(posedge tck) begin
    if (tap_reset_state)
      ir_fresh_reg <= 1'b1;
    else if (tap_update_ir)
      ir_fresh_reg <= 1'b0;
  end

  a_tdo_oe_shift: assert property (@(posedge tck)
    disable iff (tap_reset_state) tdo_oe == (tap_shift_dr || tap_shift_ir))
    else $error("tdo_oe does not follow shift state");
  a_idle_tdo_off: assert property (@(posedge tck)
    disable iff (tap_reset_state) tap_run_idle [*2] |-> !tdo_oe)
    else $error("tdo driven in idle");
  a_ir_cap_lsb: assert property (@(posedge tck)
    disable iff (tap_reset_state) tap_capture_ir ##1 tap_shift_ir |-> tdo)
    else $error("instruction capture bit 0 wrong");
  a_ir_cap_bit1: assert property (@(posedge tck)
    disable iff (tap_reset_state)
    tap_capture_ir ##1 tap_shift_ir [*2] |-> !tdo)
    else $error("instruction capture bit 1 wrong");
  a_bypass_after_reset: assert property (@(posedge tck)
    disable iff (tap_reset_state)
    ir_fresh_reg && tap_capture_dr ##1 tap_shift_dr |-> !tdo)
    else $error("bypass stage did not capture zero");
  a_reset_zero: assert property (@(posedge sys_clk)
    disable iff (reset) $fell(reset) |-> !test_mode && !highz_mode
    && a_test_out == 8'h00 && b_test_out == 8'h00)
    else $error("outputs not zero after reset");
  a_highz_drive: assert property (@(posedge sys_clk)
    disable iff (reset)
    highz_mode |-> !a_side_drive_enable && !b_side_drive_enable)
    else $error("drive enable high in highz");
  a_ce_freeze: assert property (@(posedge sys_clk)
    disable iff (reset) !sys_ce |=> $stable(test_mode)
    && $stable(a_test_out) && $stable(b_test_out))
    else $error("outputs moved while frozen");
endmodule : scan_port_chk

/* sim/boundary_scan_data_regs_tb.sv */
/*
  Bench for the scan data registers: host model, random pins, opcode
  table. Assumes free tck at 80 ns and sys_clk at 100 ns.
*/
`timescale 1ns/1ps
module boundary_scan_data_regs_tb;
  import scan_regs_pkg::*;
  logic        sys_clk;
  logic        reset;
  logic        sys_ce;
  logic        tck;
  logic        tdi;
  logic        tdo;
  logic        tdo_oe;
  logic [7:0]  st;
  logic [7:0]  a_pin_in;
  logic [7:0]  b_pin_in;
  logic [5:0]  ctrl_pin_in;
  logic [7:0]  core_a_out;
  logic [7:0]  core_b_out;
  logic        test_mode;
  logic        highz_mode;
  logic        a_side_drive_enable;
  logic        b_side_drive_enable;
  logic [7:0]  a_test_out;
  logic [7:0]  b_test_out;
  logic [7:0]  core_a_in_test;
  logic [7:0]  core_b_in_test;
  logic [5:0]  ctrl_test;
  logic [63:0] d;
  logic [63:0] dout;
  logic [7:0]  op;
  int          failures;
  int          samples_checked;
  // Control scan 8e comes before run test 09 in this list; control scan 0f comes after it
  logic [7:0]  defs [20] = '{8'h00, 8'h81, 8'h82, 8'h03, 8'h84, 8'h05,
    8'h06, 8'h87, 8'h88, 8'h8e, 8'h09, 8'h0a, 8'h8b, 8'h0c, 8'h8d,
    8'h0f, 8'h80, 8'h01, 8'h02, 8'h83};

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial begin
    tck = 1'b0;
    #13;
    forever #40 tck = ~tck;
  end

  boundary_scan_data_regs u_dut (.tap_reset_state(st[7]),
    .tap_run_idle(st[6]), .tap_capture_dr(st[5]), .tap_shift_dr(st[4]),
    .tap_update_dr(st[3]), .tap_capture_ir(st[2]), .tap_shift_ir(st[1]),
    .tap_update_ir(st[0]), .*);
  tap_host u_host (.tck(tck), .tdo(tdo), .tdi(tdi), .st(st));

  task automatic chk(input logic [63:0] got, input logic [63:0] exp,
                     input string what);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic close_out;
    $display("compares %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out

  function automatic int sel_len(input logic [7:0] c);
    case (c)
      8'h00, 8'h03, 8'h82, 8'h0a, 8'h8b, 8'h0c: return 40;
      8'h8e, 8'h0f: return 11;
      default: return 1;
    endcase
  endfunction : sel_len
  function automatic logic is_test(input logic [7:0] c);
    return c inside {8'h00, 8'h03, 8'h87, 8'h09, 8'h8b, 8'h8d, 8'h0f};
  endfunction : is_test
  function automatic logic [63:0] cap_exp();
    return 64'({~ctrl_pin_in[5] | ~ctrl_pin_in[1],
      ~ctrl_pin_in[4] | ~ctrl_pin_in[0], ctrl_pin_in, a_pin_in,
      core_a_out, b_pin_in, core_b_out});
  endfunction : cap_exp
  function automatic logic [63:0] shadow();
    return 64'({b_side_drive_enable, a_side_drive_enable, ctrl_test,
      core_a_in_test, a_test_out, core_b_in_test, b_test_out, test_mode});
  endfunction : shadow

  task automatic ir(input logic [7:0] c);
    u_host.scan(1'b1, 8, 64'(c), dout);
  endtask : ir
  task automatic dr(input int n, input logic [63:0] v);
    u_host.scan(1'b0, n, v, dout);
  endtask : dr
  // Two publish rounds to sys_clk, with margin for sys_ce gaps
  task automatic settle;
    repeat (32) @(posedge tck);
  endtask : settle
  task automatic new_pins;
    @(posedge sys_clk);
    a_pin_in <= 8'($urandom);
    b_pin_in <= 8'($urandom);
    ctrl_pin_in <= 6'($urandom);
    core_a_out <= 8'($urandom);
    core_b_out <= 8'($urandom);
    settle();
  endtask : new_pins

  task automatic reset_checks;
    u_host.hold(8'h40, 2);
    settle();
    chk(shadow(), 64'h0, "reset shadow");
    d = {$urandom, $urandom};
    dr(8, d);
    chk(64'(dout[7:0]), 64'({d[6:0], 1'b0}), "bypass");
    ir(8'h8e);
    chk(64'(dout[7:0]), 64'h81, "ir capture");
    dr(11, d);
    chk(64'(dout[10:0]), 64'h002, "ctrl reset");
    dr(11, ~d);
    chk(64'(dout[10:0]), 64'(d[10:0]), "ctrl scan");
    $display("test reset values done");
  endtask : reset_checks

  task automatic try_op(input logic [7:0] c);
    int n;
    logic [63:0] r;
    n = sel_len(c);
    r = {$urandom, $urandom} & 64'hffff_ffff_ffff;
    ir(c);
    settle();
    chk(64'({c == 8'h06 ? 1'b0 : test_mode, highz_mode}),
        64'({is_test(c), c == 8'h06}), "mode");
    dr(48, r);
    chk(dout >> n, r & ((64'h1 << (48 - n)) - 1), "path");
    if (c inside {8'h0a, 8'h8b, 8'h0c, 8'h8e, 8'h0f}) begin
      dr(48, r);
      chk(dout & ((64'h1 << n) - 1), ((c == 8'h0c) ? ~(r >> (48 - n)) :
          r >> (48 - n)) & ((64'h1 << n) - 1), "hold");
    end
  endtask : try_op

  always @(posedge sys_clk)
    if (!reset)
      sys_ce <= ($urandom_range(7) != 0);

  // Whole run is near 0.28 ms; about ten times that means a hang
  initial begin
    #3_000_000;
    failures++;
    $display("[FAIL] %0t watchdog expired", $time);
    close_out();
  end

  initial begin
    reset = 1'b1;
    sys_ce = 1'b1;
    {a_pin_in, b_pin_in, ctrl_pin_in, core_a_out, core_b_out} = '0;
    failures = 0;
    samples_checked = 0;
    void'($urandom(36));
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    reset_checks();
    ir(8'h82);
    repeat (3) begin
      new_pins();
      dr(40, {$urandom, $urandom});
      chk(dout, cap_exp(), "sample");
    end
    $display("test sample done");
    ir(8'h00);
    d = {$urandom, $urandom};
    d[39:38] = 2'b11;
    dr(40, d);
    chk(dout, cap_exp(), "extest capture");
    settle();
    chk(shadow(), 64'({d[39:0], 1'b1}), "preload");
    ir(8'h06);
    settle();
    chk(64'({highz_mode, a_side_drive_enable, b_side_drive_enable}),
        64'h4, "highz");
    // Each ir() pair below leaves exactly one idle edge between them
    d[39:38] = 2'b01;
    ir(8'h00);
    dr(40, d);
    ir(8'h8d);
    ir(8'h0a);
    dr(40, d);
    chk(dout, 64'(d[39:0] ^ 40'h00_00ff_00ff), "toggle");
    ir(8'h8e);
    dr(11, 64'h0);
    ir(8'h09);
    ir(8'h0a);
    dr(40, d);
    chk(dout, 64'({d[39:32], a_pin_in, ~d[23:16], b_pin_in, ~d[7:0]}),
        "run sample");
    $display("test preload done");
    foreach (defs[k])
      try_op(defs[k]);
    repeat (6) begin
      do
        op = 8'($urandom);
      while (op inside {defs});
      try_op(op);
    end
    $display("test opcode table done");
    ir(8'h03);
    dr(40, 64'hff_ffff_ffff);
    u_host.hold(8'h80, 16);
    reset_checks();
    close_out();
  end
endmodule : boundary_scan_data_regs_tb

bind boundary_scan_data_regs scan_port_chk u_chk (.*);
